//--- bench/camirq_core_model.sv
// Processor-side model that issues instruction and data accesses
`timescale 1ns/1ps
`default_nettype none
module camirq_core_model (
   input  wire logic        clk,
   input  wire logic        req_ready,
   output logic             req_valid,
   output logic [31:0]      req_addr,
   output logic             req_fetch,
   output logic             req_write,
   output logic             req_priv,
   output logic             sys_prot_deny
);
   initial begin
      req_valid = 1'h0;
      req_addr = 32'h0;
      req_fetch = 1'h0;
      req_write = 1'h0;
      req_priv = 1'h0;
      sys_prot_deny = 1'h0;
   end
   // ****
   // Access issue
   // ****
   // Ready is sampled settled, before the edge, to avoid an edge race
   task automatic issue(input logic [31:0] a, input logic f, input logic w,
                        input logic p, input logic d, input int gap);
      int   n;
      logic rdy;
      n = 0;
      repeat (gap + 1) @(posedge clk);
      #1;
      req_valid = 1'h1;
      req_addr = a;
      req_fetch = f;
      req_write = w;
      req_priv = p;
      sys_prot_deny = d;
      do begin
         rdy = req_ready;
         @(posedge clk);
         #1;
         n++;
      end while (rdy !== 1'h1 && n < 8);
      // Released address, fetch and deny lines show the inverse so stale values never match
      req_valid = 1'h0;
      req_addr = ~a;
      req_fetch = ~f;
      sys_prot_deny = ~d;
   endtask : issue
endmodule : camirq_core_model
`default_nettype wire

//--- bench/cpu_address_map_and_irq_fanout_tb.sv
// Self-checking bench for the address map and interrupt fan-out
`timescale 1ns/1ps
`default_nettype none
module cpu_address_map_and_irq_fanout_tb;
   import camirq_pkg::*;
   typedef struct {
      logic [31:0]    a;
      logic           f;
      logic           w;
      camirq_target_e tg;
      camirq_fault_e  cs;
      logic [2:0]     rt;
      int             lat;
   } camirq_row_s;
   logic clk = 1'h0, nrst = 1'h0, fault_clr = 1'h0, deep_sleep = 1'h0;
   logic rgn_we = 1'h0, rgn_en = 1'h0, rgn_user_rd = 1'h0, rgn_exec = 1'h0;
   logic rgn_user_wr = 1'h0, vtor_we = 1'h0, prio_we = 1'h0;
   logic [2:0]  rgn_idx = 3'h0, prio_wdata = 3'h0;
   logic [4:0]  prio_idx = 5'h0;
   logic [31:0] rgn_base = 32'h0, rgn_limit = 32'h0, vtor_wdata = 32'h0;
   logic [31:0] periph_irq = 32'h0;
   logic req_valid, req_fetch, req_write, req_priv, sys_prot_deny, req_ready;
   logic rsp_valid, rsp_internal, rsp_apb, rsp_sys_ahb, rsp_fault;
   logic memory_management_fault, nmi, core_wake;
   logic [31:0] req_addr, rsp_addr, fault_addr, vector_base;
   logic [31:0] nested_vectored_irq_ctrl, wakeup_irq_ctrl;
   logic [95:0] irq_prio;
   camirq_target_e rsp_target;
   camirq_fault_e  fault_cause;
   int bad_count = 0, cmp_count = 0, cycles = 0;

   always #25 clk = ~clk;

   camirq_top camirq_top_inst (.clk(clk), .nrst(nrst), .req_valid(req_valid),
      .req_addr(req_addr), .req_fetch(req_fetch), .req_write(req_write),
      .req_priv(req_priv), .sys_prot_deny(sys_prot_deny),
      .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_target(rsp_target),
      .rsp_addr(rsp_addr), .rsp_internal(rsp_internal), .rsp_apb(rsp_apb),
      .rsp_sys_ahb(rsp_sys_ahb), .rsp_fault(rsp_fault),
      .memory_management_fault(memory_management_fault),
      .fault_cause(fault_cause), .fault_addr(fault_addr), .rgn_we(rgn_we),
      .rgn_idx(rgn_idx), .rgn_base(rgn_base), .rgn_limit(rgn_limit),
      .rgn_en(rgn_en), .rgn_user_rd(rgn_user_rd), .rgn_user_wr(rgn_user_wr),
      .rgn_exec(rgn_exec), .fault_clr(fault_clr), .vtor_we(vtor_we),
      .vtor_wdata(vtor_wdata), .vector_base(vector_base),
      .periph_irq(periph_irq), .prio_we(prio_we), .prio_idx(prio_idx),
      .prio_wdata(prio_wdata), .deep_sleep(deep_sleep),
      .nested_vectored_irq_ctrl(nested_vectored_irq_ctrl),
      .wakeup_irq_ctrl(wakeup_irq_ctrl), .irq_prio(irq_prio), .nmi(nmi),
      .core_wake(core_wake));

   camirq_core_model camirq_core_model_inst (.clk(clk),
      .req_ready(req_ready), .req_valid(req_valid), .req_addr(req_addr),
      .req_fetch(req_fetch), .req_write(req_write), .req_priv(req_priv),
      .sys_prot_deny(sys_prot_deny));

   // ****
   // Shared helpers
   // ****
   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : tally_and_finish

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Low gap after the pulse so back-to-back strobes never merge
   task automatic strobe(ref logic s);
      s = 1'h1;
      @(posedge clk);
      #1;
      s = 1'h0;
      @(posedge clk);
      #1;
   endtask : strobe

   // Route bits {internal, apb, sys_ahb}; all low unless routed there
   task automatic access(input camirq_row_s r, input logic p, input logic d,
                         input int gap);
      int lat;
      lat = 1;
      camirq_core_model_inst.issue(r.a, r.f, r.w, p, d, gap);
      if (r.lat == 2) chk(req_ready, 1'h0);
      // Response pulse may already stand in the cycle after the take
      while (rsp_valid !== 1'h1 && lat < 4) begin
         @(posedge clk);
         #1;
         lat++;
      end
      chk(lat, r.lat);
      chk(rsp_target, r.tg);
      chk(rsp_addr, r.a);
      chk(rsp_fault, r.cs != CAMIRQ_F_NONE);
      chk({rsp_internal, rsp_apb, rsp_sys_ahb}, r.rt);
      if (r.cs != CAMIRQ_F_NONE) begin
         chk(memory_management_fault, 1'h1);
         chk(fault_cause, r.cs);
         chk(fault_addr, r.a);
         strobe(fault_clr);
         chk(memory_management_fault, 1'h0);
         chk(fault_cause, CAMIRQ_F_NONE);
      end
   endtask : access

   // ****
   // Scenarios
   // ****
   task automatic t_reset();
      chk(req_ready, 1'h1);
      chk(rsp_valid, 1'h0);
      chk(memory_management_fault, 1'h0);
      chk(vector_base, 32'h0);
      chk(nmi, 1'h0);
      chk(rsp_target, CAMIRQ_T_NVM);
      chk(fault_cause, CAMIRQ_F_NONE);
      chk(core_wake, 1'h0);
   endtask : t_reset

   task automatic t_map();
      camirq_row_s tbl[17] = '{
         '{32'h00000100, 1'h1, 1'h0, CAMIRQ_T_NVM, CAMIRQ_F_NONE, 3'h0, 1},
         '{32'h10000040, 1'h1, 1'h0, CAMIRQ_T_SRAM, CAMIRQ_F_NONE, 3'h0, 1},
         '{32'h10100000, 1'h0, 1'h1, CAMIRQ_T_TCM, CAMIRQ_F_NONE, 3'h0, 1},
         '{32'h00200000, 1'h0, 1'h1, CAMIRQ_T_RSVD, CAMIRQ_F_UNMAPPED, 3'h0, 1},
         '{32'h20000000, 1'h1, 1'h0, CAMIRQ_T_RSVD, CAMIRQ_F_XN, 3'h0, 1},
         '{32'h3FFFFFFC, 1'h0, 1'h0, CAMIRQ_T_RSVD, CAMIRQ_F_UNMAPPED, 3'h0, 1},
         '{32'h40000000, 1'h0, 1'h0, CAMIRQ_T_PERIPH, CAMIRQ_F_NONE, 3'h0, 2},
         '{32'h5FFFFFFC, 1'h1, 1'h0, CAMIRQ_T_PERIPH, CAMIRQ_F_XN, 3'h0, 1},
         '{32'h60000000, 1'h1, 1'h0, CAMIRQ_T_EXTMEM, CAMIRQ_F_NONE, 3'h0, 1},
         '{32'h9FFFFFFC, 1'h0, 1'h1, CAMIRQ_T_EXTMEM, CAMIRQ_F_NONE, 3'h0, 1},
         '{32'hA0000000, 1'h1, 1'h0, CAMIRQ_T_EXTDEV, CAMIRQ_F_XN, 3'h0, 1},
         '{32'hDFFFFFFC, 1'h0, 1'h1, CAMIRQ_T_EXTDEV, CAMIRQ_F_NONE, 3'h0, 1},
         '{32'hE0043FFF, 1'h0, 1'h0, CAMIRQ_T_PPB_INT, CAMIRQ_F_NONE, 3'h4, 1},
         '{32'hE0044000, 1'h0, 1'h0, CAMIRQ_T_PPB_EXT, CAMIRQ_F_NONE, 3'h2, 1},
         '{32'hE00FFFFF, 1'h1, 1'h0, CAMIRQ_T_PPB_EXT, CAMIRQ_F_XN, 3'h0, 1},
         '{32'hE0100000, 1'h0, 1'h0, CAMIRQ_T_VSYS, CAMIRQ_F_NONE, 3'h1, 1},
         '{32'hFFFFFFFC, 1'h1, 1'h0, CAMIRQ_T_VSYS, CAMIRQ_F_XN, 3'h0, 1}};
      foreach (tbl[i]) begin
         access(tbl[i], 1'h1, 1'h0, 0);
      end
   endtask : t_map

   // Region 7 grants user reads of 0x0-0xFFF only
   task automatic t_prot();
      access('{32'h100, 1'h0, 1'h0, CAMIRQ_T_NVM, CAMIRQ_F_REGION, 3'h0, 1},
             1'h0, 1'h0, 2);
      rgn_idx = 3'h7;
      rgn_limit = 32'h00000FFF;
      rgn_en = 1'h1;
      rgn_user_rd = 1'h1;
      strobe(rgn_we);
      access('{32'hFFC, 1'h0, 1'h0, CAMIRQ_T_NVM, CAMIRQ_F_NONE, 3'h0, 1},
             1'h0, 1'h0, 0);
      access('{32'h1000, 1'h0, 1'h0, CAMIRQ_T_NVM, CAMIRQ_F_REGION, 3'h0, 1},
             1'h0, 1'h0, 0);
      access('{32'h100, 1'h0, 1'h1, CAMIRQ_T_NVM, CAMIRQ_F_REGION, 3'h0, 1},
             1'h0, 1'h0, 1);
      access('{32'h100, 1'h1, 1'h0, CAMIRQ_T_NVM, CAMIRQ_F_REGION, 3'h0, 1},
             1'h0, 1'h0, 0);
      access('{32'h100, 1'h0, 1'h0, CAMIRQ_T_NVM, CAMIRQ_F_SYSPROT, 3'h0, 1},
             1'h1, 1'h1, 0);
   endtask : t_prot

   task automatic t_irq();
      periph_irq = 32'h80000001;
      @(posedge clk);
      #1;
      chk(nested_vectored_irq_ctrl, 32'h80000001);
      chk(wakeup_irq_ctrl, 32'h80000001);
      chk(core_wake, 1'h0);
      deep_sleep = 1'h1;
      periph_irq = 32'h0;
      @(posedge clk);
      #1;
      chk(core_wake, 1'h0);
      periph_irq = 32'h00000400;
      @(posedge clk);
      #1;
      chk(core_wake, 1'h1);
      chk(wakeup_irq_ctrl, 32'h00000400);
      chk(nmi, 1'h0);
      deep_sleep = 1'h0;
      periph_irq = 32'h0;
   endtask : t_irq

   task automatic t_cfg();
      prio_wdata = 3'h7;
      strobe(prio_we);
      prio_idx = 5'h1F;
      prio_wdata = 3'h5;
      strobe(prio_we);
      chk(irq_prio[2:0], 3'h7);
      chk(irq_prio[95:93], 3'h5);
      chk(irq_prio[5:3], 3'h0);
      vtor_wdata = 32'h100000FF;
      strobe(vtor_we);
      chk(vector_base, 32'h10000080);
      // Second reset in mid-run must drop the relocated base
      nrst = 1'h0;
      @(posedge clk);
      #1;
      nrst = 1'h1;
      chk(vector_base, 32'h0);
      chk(irq_prio[2:0], 3'h0);
      chk(irq_prio[95:93], 3'h0);
      chk(req_ready, 1'h1);
      chk(rsp_valid, 1'h0);
      chk(memory_management_fault, 1'h0);
   endtask : t_cfg

   always @(posedge clk) begin
      cycles++;
      if (cycles == 4000) begin
         bad_count++;
         tally_and_finish();
      end
   end

   initial begin
      repeat (8) @(posedge clk);
      #1;
      nrst = 1'h1;
      t_reset();
      t_map();
      t_prot();
      t_irq();
      t_cfg();
      tally_and_finish();
   end
endmodule : cpu_address_map_and_irq_fanout_tb
`default_nettype wire

//--- core/camirq_decode.sv
// Combinational address decoder for the flat 4 GB map
`timescale 1ns/1ps
`default_nettype none
`include "camirq_params.svh"
module camirq_decode (
   input  wire logic [31:0]               addr,
   output camirq_pkg::camirq_target_e     target,
   output logic                           exec_ok,
   output logic                           mapped
);
   import camirq_pkg::*;

   wire in_sram = addr >= `CAMIRQ_SRAM_BASE &&
                  addr < (`CAMIRQ_SRAM_BASE + `CAMIRQ_SRAM_SIZE);
   wire in_tcm  = addr >= `CAMIRQ_TCM_BASE &&
                  addr < (`CAMIRQ_TCM_BASE + `CAMIRQ_TCM_SIZE);
   wire in_nvm  = addr < `CAMIRQ_NVM_SIZE;

   always_comb begin
      target  = CAMIRQ_T_RSVD;
      exec_ok = 1'b0;
      mapped  = 1'b1;
      if (addr >= `CAMIRQ_VSYS_BASE) begin
         target = CAMIRQ_T_VSYS;
      end else if (addr >= `CAMIRQ_PPB_EXT_BASE) begin
         target = CAMIRQ_T_PPB_EXT;
      end else if (addr >= `CAMIRQ_PPB_BASE) begin
         target = CAMIRQ_T_PPB_INT;
      end else if (addr >= `CAMIRQ_EXTDEV_BASE) begin
         target = CAMIRQ_T_EXTDEV;
      end else if (addr >= `CAMIRQ_EXTMEM_BASE) begin
         target  = CAMIRQ_T_EXTMEM;
         exec_ok = 1'b1;
      end else if (addr >= `CAMIRQ_PERIPH_BASE) begin
         target = CAMIRQ_T_PERIPH;
      end else if (addr >= `CAMIRQ_RSVD_BASE) begin
         target = CAMIRQ_T_RSVD;
         mapped = 1'b0;
      end else if (in_tcm) begin
         target  = CAMIRQ_T_TCM;
         exec_ok = 1'b1;
      end else if (in_sram) begin
         target  = CAMIRQ_T_SRAM;
         exec_ok = 1'b1;
      end else if (in_nvm) begin
         target  = CAMIRQ_T_NVM;
         exec_ok = 1'b1;
      end else begin
         mapped = 1'b0;
      end
   end
endmodule : camirq_decode
`default_nettype wire

//--- core/camirq_params.svh
// Constants for the processor address map and interrupt fan-out
`ifndef CAMIRQ_PARAMS_SVH
`define CAMIRQ_PARAMS_SVH
`define CAMIRQ_N_IRQ        32
`define CAMIRQ_PRIO_W       3
`define CAMIRQ_N_PRIO       8
`define CAMIRQ_N_REGION     8
`define CAMIRQ_CODE_BASE    32'h00000000
`define CAMIRQ_RSVD_BASE    32'h20000000
`define CAMIRQ_PERIPH_BASE  32'h40000000
`define CAMIRQ_EXTMEM_BASE  32'h60000000
`define CAMIRQ_EXTDEV_BASE  32'hA0000000
`define CAMIRQ_PPB_BASE     32'hE0000000
`define CAMIRQ_PPB_INT_END  32'hE0043FFF
`define CAMIRQ_PPB_EXT_BASE 32'hE0044000
`define CAMIRQ_PPB_END      32'hE00FFFFF
`define CAMIRQ_VSYS_BASE    32'hE0100000
`define CAMIRQ_NVM_SIZE     32'h00200000
`define CAMIRQ_SRAM_BASE    32'h10000000
`define CAMIRQ_SRAM_SIZE    32'h00100000
`define CAMIRQ_TCM_BASE     32'h10100000
`define CAMIRQ_TCM_SIZE     32'h00060000
`define CAMIRQ_VTOR_RESET   32'h00000000
`define CAMIRQ_APB_WAIT     2'h1
`endif

//--- core/camirq_pkg.sv
// Types for the processor address map and interrupt fan-out
package camirq_pkg;
   typedef enum logic [3:0] {
      CAMIRQ_T_NVM, CAMIRQ_T_SRAM, CAMIRQ_T_TCM, CAMIRQ_T_RSVD,
      CAMIRQ_T_PERIPH, CAMIRQ_T_EXTMEM, CAMIRQ_T_EXTDEV,
      CAMIRQ_T_PPB_INT, CAMIRQ_T_PPB_EXT, CAMIRQ_T_VSYS
   } camirq_target_e;
   typedef enum logic [2:0] {
      CAMIRQ_F_NONE, CAMIRQ_F_XN, CAMIRQ_F_REGION, CAMIRQ_F_SYSPROT,
      CAMIRQ_F_UNMAPPED
   } camirq_fault_e;
endpackage : camirq_pkg

//--- core/camirq_top.sv
// Processor address map, access qualifier and interrupt fan-out
`timescale 1ns/1ps
`default_nettype none
`include "camirq_params.svh"
module camirq_top (
   input  wire logic                             clk,
   input  wire logic                             nrst,
   // Processor access request
   input  wire logic                             req_valid,
   input  wire logic [31:0]                      req_addr,
   input  wire logic                             req_fetch,
   input  wire logic                             req_write,
   input  wire logic                             req_priv,
   input  wire logic                             sys_prot_deny,
   output logic                                  req_ready,
   // Routed access
   output logic                                  rsp_valid,
   output camirq_pkg::camirq_target_e            rsp_target,
   output logic [31:0]                           rsp_addr,
   output logic                                  rsp_internal,
   output logic                                  rsp_apb,
   output logic                                  rsp_sys_ahb,
   output logic                                  rsp_fault,
   output logic                                  memory_management_fault,
   output camirq_pkg::camirq_fault_e             fault_cause,
   output logic [31:0]                           fault_addr,
   // Protection region programming
   input  wire logic                             rgn_we,
   input  wire logic [2:0]                       rgn_idx,
   input  wire logic [31:0]                      rgn_base,
   input  wire logic [31:0]                      rgn_limit,
   input  wire logic                             rgn_en,
   input  wire logic                             rgn_user_rd,
   input  wire logic                             rgn_user_wr,
   input  wire logic                             rgn_exec,
   input  wire logic                             fault_clr,
   // Vector table relocation
   input  wire logic                             vtor_we,
   input  wire logic [31:0]                      vtor_wdata,
   output logic [31:0]                           vector_base,
   // Interrupts
   input  wire logic [`CAMIRQ_N_IRQ-1:0]         periph_irq,
   input  wire logic                             prio_we,
   input  wire logic [4:0]                       prio_idx,
   input  wire logic [`CAMIRQ_PRIO_W-1:0]        prio_wdata,
   input  wire logic                             deep_sleep,
   output logic [`CAMIRQ_N_IRQ-1:0]              nested_vectored_irq_ctrl,
   output logic [`CAMIRQ_N_IRQ-1:0]              wakeup_irq_ctrl,
   output logic [`CAMIRQ_N_IRQ*`CAMIRQ_PRIO_W-1:0] irq_prio,
   output logic                                  nmi,
   output logic                                  core_wake
);
   import camirq_pkg::*;

   // ****************************************************************
   // Interrupt fan-out and priority
   // ****************************************************************
   logic [`CAMIRQ_PRIO_W-1:0] prio_ff [`CAMIRQ_N_IRQ];
   logic                      wake_ff;

   assign nested_vectored_irq_ctrl = periph_irq;
   assign wakeup_irq_ctrl          = periph_irq;
   assign nmi                      = 1'b0;
   wire   nxt_wake = deep_sleep && (|periph_irq);

   genvar gi;
   generate
      for (gi = 0; gi < `CAMIRQ_N_IRQ; gi++) begin : g_prio
         always_ff @(posedge clk) begin
            if (!nrst)
               prio_ff[gi] <= '0;
            else if (prio_we && prio_idx == 5'(gi))
               prio_ff[gi] <= prio_wdata;
         end
         assign irq_prio[gi*`CAMIRQ_PRIO_W +: `CAMIRQ_PRIO_W] = prio_ff[gi];
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (!nrst)
         wake_ff <= 1'b0;
      else
         wake_ff <= nxt_wake;
   end
   assign core_wake = wake_ff;

   // ****************************************************************
   // Vector table base
   // ****************************************************************
   logic [31:0] vtor_ff;
   always_ff @(posedge clk) begin
      if (!nrst)
         vtor_ff <= `CAMIRQ_VTOR_RESET;
      else if (vtor_we)
         vtor_ff <= {vtor_wdata[31:7], 7'h00};
   end
   assign vector_base = vtor_ff;

   // ****************************************************************
   // Protection regions
   // ****************************************************************
   logic [31:0] rb_ff [`CAMIRQ_N_REGION];
   logic [31:0] rl_ff [`CAMIRQ_N_REGION];
   logic [3:0]  ra_ff [`CAMIRQ_N_REGION];
   logic [`CAMIRQ_N_REGION-1:0] hit;
   logic [`CAMIRQ_N_REGION-1:0] allow;

   generate
      for (gi = 0; gi < `CAMIRQ_N_REGION; gi++) begin : g_rgn
         always_ff @(posedge clk) begin
            if (!nrst) begin
               rb_ff[gi] <= '0;
               rl_ff[gi] <= '0;
               ra_ff[gi] <= '0;
            end else if (rgn_we && rgn_idx == 3'(gi)) begin
               rb_ff[gi] <= rgn_base;
               rl_ff[gi] <= rgn_limit;
               ra_ff[gi] <= {rgn_en, rgn_user_rd, rgn_user_wr, rgn_exec};
            end
         end
         assign hit[gi] = ra_ff[gi][3] && req_addr >= rb_ff[gi] &&
                          req_addr <= rl_ff[gi];
         assign allow[gi] = req_fetch ? ra_ff[gi][0] :
                            req_write ? ra_ff[gi][1] : ra_ff[gi][2];
      end
   endgenerate

   // Privileged code bypasses regions; unprivileged needs one granting hit
   wire rgn_block = !req_priv && !(|(hit & allow));

   // ****************************************************************
   // Address decode and qualification
   // ****************************************************************
   camirq_target_e dec_target;
   logic           dec_exec;
   logic           dec_mapped;

   camirq_decode camirq_decode_inst (
      .addr    (req_addr),
      .target  (dec_target),
      .exec_ok (dec_exec),
      .mapped  (dec_mapped)
   );

   wire xn_fault  = req_fetch && !dec_exec;
   wire any_fault = xn_fault || rgn_block || sys_prot_deny || !dec_mapped;
   wire is_ppb_ext = dec_target == CAMIRQ_T_PPB_EXT;
   wire is_vsys    = dec_target == CAMIRQ_T_VSYS;
   wire is_periph  = dec_target == CAMIRQ_T_PERIPH;

   camirq_fault_e nxt_cause;
   always_comb begin
      if (xn_fault)
         nxt_cause = CAMIRQ_F_XN;
      else if (!dec_mapped)
         nxt_cause = CAMIRQ_F_UNMAPPED;
      else if (rgn_block)
         nxt_cause = CAMIRQ_F_REGION;
      else
         nxt_cause = CAMIRQ_F_SYSPROT;
   end

   // ****************************************************************
   // Access sequencer with one bridge wait state
   // ****************************************************************
   typedef enum logic [1:0] {CAMIRQ_S_IDLE, CAMIRQ_S_WAIT} camirq_st_e;
   camirq_st_e st_ff;
   camirq_st_e nxt_st;
   logic       take;
   logic       launch;

   assign req_ready = st_ff == CAMIRQ_S_IDLE;
   assign take      = req_valid && req_ready;
   // Bridged peripheral data access holds one extra cycle
   wire   needs_wait = take && is_periph && !any_fault;
   assign launch    = (take && !needs_wait) || st_ff == CAMIRQ_S_WAIT;

   always_comb begin
      case (st_ff)
         CAMIRQ_S_IDLE: nxt_st = needs_wait ? CAMIRQ_S_WAIT : CAMIRQ_S_IDLE;
         CAMIRQ_S_WAIT: nxt_st = CAMIRQ_S_IDLE;
         default:       nxt_st = CAMIRQ_S_IDLE;
      endcase
   end

   logic           hold_fault_ff;
   camirq_target_e hold_tgt_ff;
   logic [31:0]    hold_addr_ff;
   logic           fault_ff;
   camirq_fault_e  cause_ff;
   logic [31:0]    faddr_ff;
   logic           rv_ff;
   camirq_target_e rt_ff;
   logic [31:0]    ra_out_ff;
   logic           rint_ff;
   logic           rapb_ff;
   logic           rahb_ff;
   logic           rfault_ff;

   wire            cur_fault = take ? any_fault : hold_fault_ff;
   camirq_target_e cur_tgt;
   assign cur_tgt = take ? dec_target : hold_tgt_ff;
   wire [31:0]     cur_addr = take ? req_addr : hold_addr_ff;
   wire            fault_set = take && any_fault;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         st_ff         <= CAMIRQ_S_IDLE;
         hold_fault_ff <= 1'b0;
         hold_tgt_ff   <= CAMIRQ_T_NVM;
         hold_addr_ff  <= '0;
      end else begin
         st_ff <= nxt_st;
         if (take) begin
            hold_fault_ff <= any_fault;
            hold_tgt_ff   <= dec_target;
            hold_addr_ff  <= req_addr;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         rv_ff     <= 1'b0;
         rt_ff     <= CAMIRQ_T_NVM;
         ra_out_ff <= '0;
         rint_ff   <= 1'b0;
         rapb_ff   <= 1'b0;
         rahb_ff   <= 1'b0;
         rfault_ff <= 1'b0;
      end else begin
         rv_ff     <= launch;
         rt_ff     <= cur_tgt;
         ra_out_ff <= cur_addr;
         rfault_ff <= launch && cur_fault;
         rint_ff   <= launch && !cur_fault &&
                      cur_tgt == CAMIRQ_T_PPB_INT;
         rapb_ff   <= launch && !cur_fault &&
                      cur_tgt == CAMIRQ_T_PPB_EXT;
         rahb_ff   <= launch && !cur_fault &&
                      cur_tgt == CAMIRQ_T_VSYS;
      end
   end

   // Sticky fault record; a new fault on the clear cycle wins
   always_ff @(posedge clk) begin
      if (!nrst) begin
         fault_ff <= 1'b0;
         cause_ff <= CAMIRQ_F_NONE;
         faddr_ff <= '0;
      end else if (fault_set) begin
         fault_ff <= 1'b1;
         cause_ff <= nxt_cause;
         faddr_ff <= req_addr;
      end else if (fault_clr) begin
         fault_ff <= 1'b0;
         cause_ff <= CAMIRQ_F_NONE;
      end
   end

   assign rsp_valid               = rv_ff;
   assign rsp_target              = rt_ff;
   assign rsp_addr                = ra_out_ff;
   assign rsp_internal            = rint_ff;
   assign rsp_apb                 = rapb_ff;
   assign rsp_sys_ahb             = rahb_ff;
   assign rsp_fault               = rfault_ff;
   assign memory_management_fault = fault_ff;
   assign fault_cause             = cause_ff;
   assign fault_addr              = faddr_ff;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   chk_irq_fanout: assert property (
      nested_vectored_irq_ctrl == periph_irq && wakeup_irq_ctrl == periph_irq)
      else $error("irq fan-out mismatch");
   chk_wake_sleep: assert property (
      deep_sleep && (|periph_irq) |=> core_wake)
      else $error("no wake in deep sleep");
   chk_nmi_never: assert property (!nmi)
      else $error("nmi raised");
   chk_prio_write: assert property (
      prio_we |=> irq_prio[$past(prio_idx)*3 +: 3] == $past(prio_wdata))
      else $error("priority not stored");
   chk_vtor_move: assert property (
      vtor_we |=> vector_base[31:7] == $past(vtor_wdata[31:7]))
      else $error("vector base not moved");
   chk_xn_fault: assert property (
      take && req_fetch && req_addr >= `CAMIRQ_PPB_BASE |=> rsp_fault
      && memory_management_fault && fault_cause == CAMIRQ_F_XN)
      else $error("fetch from system space not faulted");
   chk_periph_xn: assert property (
      take && req_fetch && dec_target == CAMIRQ_T_PERIPH |=> rsp_fault)
      else $error("peripheral fetch not faulted");
   chk_ppb_int: assert property (
      take && !any_fault && dec_target == CAMIRQ_T_PPB_INT
      |=> rsp_internal && !rsp_apb && !rsp_sys_ahb)
      else $error("internal system access leaked");
   chk_ppb_apb: assert property (
      take && !any_fault && is_ppb_ext |=> rsp_apb && !rsp_internal)
      else $error("private APB access missing");
   chk_vsys_ahb: assert property (
      take && !any_fault && is_vsys |=> rsp_sys_ahb)
      else $error("vendor data access not on AHB");
   chk_apb_wait: assert property (
      needs_wait |=> !rsp_valid && !req_ready ##1 rsp_valid && req_ready)
      else $error("bridge wait state wrong");
   chk_sysprot: assert property (
      take && sys_prot_deny |=> rsp_fault && !rsp_apb && !rsp_sys_ahb)
      else $error("system protection ignored");

   cov_apb_wait: cover property (needs_wait ##2 rsp_valid);
   cov_xn_fetch: cover property (take && xn_fault);
   cov_wake:     cover property (deep_sleep && (|periph_irq) ##1 core_wake);
   cov_rgn_blk:  cover property (take && rgn_block && !xn_fault);
endmodule : camirq_top
`default_nettype wire
